// >>> core/aer_regs.sv
// Advanced error reporting register bank with APB slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
//
// Overview of operation
// - Severity register is sticky read-write; bits 0,4,13,17,18 reset to one.
// - Severity reserved bits read zero and ignore writes.
// - Correctable status bits 0,6,7,8,12 are sticky, write one to clear.
// - Correctable mask bits sit at the same positions, reset zero.
// - Five-bit sticky read-only first error pointer, reset zero.
// - ECRC capable bits read one; ECRC enables are sticky read-write.
// - Four header log words, byte zero in the top byte, reset zero.
// - Secondary status bits 0-3,5-13 are sticky write-one-to-clear.
// - Secondary bits 0-6 encode split completion and abort errors.
// - Secondary bits 7-13 encode data, address, pin and bridge errors.
// - Secondary mask bits 3,5,7,8,9,10,12 reset to one.
// - Primary uncorrectable status and mask at severity bit positions.
module aer_regs
   import aer_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         link_rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [31:0]  unc_err_det,
   input  wire logic [31:0]  cor_err_det,
   input  wire logic [31:0]  sec_err_det,
   input  wire logic [127:0] err_header,
   output logic      [31:0]  unc_severity,
   output logic              ecrc_gen_en,
   output logic              ecrc_chk_en,
   output logic              err_cor_msg,
   output logic              err_nonfatal_msg,
   output logic              err_fatal_msg,
   output logic              irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] unc_status_q;
   logic [31:0] unc_mask_q;
   logic [31:0] unc_sev_q;
   logic [31:0] cor_status_q;
   logic [31:0] cor_mask_q;
   logic        ecrc_gen_en_q;
   logic        ecrc_chk_en_q;
   logic [31:0] sec_status_q;
   logic [31:0] sec_mask_q;
   logic [31:0] irq_status_q;
   logic [31:0] irq_enable_q;
   logic [31:0] prdata_q;
   logic        slverr_q;
   logic [31:0] rdata_d;
   logic        hit_d;
   logic        setup;
   logic        wr_en;
   logic [31:0] unc_ev;
   logic [31:0] cor_ev;
   logic [31:0] sec_ev;
   logic [31:0] unc_report;
   logic [31:0] cor_report;
   logic [31:0] sec_report;
   logic        unc_pending;
   logic [4:0]  first_err_ptr;
   logic [31:0] hdr_word0;
   logic [31:0] hdr_word1;
   logic [31:0] hdr_word2;
   logic [31:0] hdr_word3;
   logic [31:0] cap_ctrl;
   logic [31:0] irq_ev;

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   assign setup   = psel && !penable;
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = psel && penable && slverr_q;

   // ----------------------------------------------------------------
   // Event qualification
   // ----------------------------------------------------------------
   assign unc_ev = unc_err_det & AER_UNC_BITS;
   assign cor_ev = cor_err_det & AER_COR_BITS;
   assign sec_ev = sec_err_det & AER_SEC_BITS;

   assign unc_report  = unc_ev & ~unc_mask_q;
   assign cor_report  = cor_ev & ~cor_mask_q;
   assign sec_report  = sec_ev & ~sec_mask_q;
   assign unc_pending = |(unc_status_q & ~unc_mask_q);

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // capability bits read as one
   always_comb begin
      cap_ctrl                   = AER_ZERO;
      cap_ctrl[AER_FEP_MSB:0]    = first_err_ptr;
      cap_ctrl[AER_ECRC_GEN_CAP] = 1'b1;
      cap_ctrl[AER_ECRC_GEN_EN]  = ecrc_gen_en_q;
      cap_ctrl[AER_ECRC_CHK_CAP] = 1'b1;
      cap_ctrl[AER_ECRC_CHK_EN]  = ecrc_chk_en_q;
   end

   always_comb begin
      rdata_d = AER_ZERO;
      hit_d   = 1'b1;
      unique case (paddr)
         AER_UNC_STATUS_ADDR: rdata_d = unc_status_q;
         AER_UNC_MASK_ADDR:   rdata_d = unc_mask_q;
         AER_UNC_SEV_ADDR:    rdata_d = unc_sev_q & AER_UNC_BITS;
         AER_COR_STATUS_ADDR: rdata_d = cor_status_q;
         AER_COR_MASK_ADDR:   rdata_d = cor_mask_q;
         AER_CAP_CTRL_ADDR:   rdata_d = cap_ctrl;
         AER_HDR_LOG0_ADDR:   rdata_d = hdr_word0;
         AER_HDR_LOG1_ADDR:   rdata_d = hdr_word1;
         AER_HDR_LOG2_ADDR:   rdata_d = hdr_word2;
         AER_HDR_LOG3_ADDR:   rdata_d = hdr_word3;
         AER_SEC_STATUS_ADDR: rdata_d = sec_status_q;
         AER_SEC_MASK_ADDR:   rdata_d = sec_mask_q;
         AER_IRQ_STATUS_ADDR: rdata_d = irq_status_q;
         AER_IRQ_ENABLE_ADDR: rdata_d = irq_enable_q;
         default:             hit_d   = 1'b0;
      endcase
   end

   // Read data and error flag are sampled in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= AER_ZERO;
         slverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? AER_ZERO : rdata_d;
         slverr_q <= !hit_d;
      end
   end

   // ----------------------------------------------------------------
   // Primary uncorrectable status, mask and severity
   // ----------------------------------------------------------------
   // primary status set over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unc_status_q <= AER_ZERO;
      end else begin
         unc_status_q <= aer_w1c(unc_status_q,
                                 wr_en && paddr == AER_UNC_STATUS_ADDR,
                                 pwdata, unc_ev, AER_UNC_BITS);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unc_mask_q <= AER_ZERO;
      end else if (wr_en && paddr == AER_UNC_MASK_ADDR) begin
         unc_mask_q <= pwdata & AER_UNC_BITS;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unc_sev_q <= AER_SEV_RESET;
      end else if (wr_en && paddr == AER_UNC_SEV_ADDR) begin
         unc_sev_q <= pwdata & AER_UNC_BITS;
      end
   end

   assign unc_severity = unc_sev_q;

   // ----------------------------------------------------------------
   // Correctable status and mask
   // ----------------------------------------------------------------
   // correctable status set over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cor_status_q <= AER_ZERO;
      end else begin
         cor_status_q <= aer_w1c(cor_status_q,
                                 wr_en && paddr == AER_COR_STATUS_ADDR,
                                 pwdata, cor_ev, AER_COR_BITS);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cor_mask_q <= AER_ZERO;
      end else if (wr_en && paddr == AER_COR_MASK_ADDR) begin
         cor_mask_q <= pwdata & AER_COR_BITS;
      end
   end

   // ----------------------------------------------------------------
   // ECRC enables
   // ----------------------------------------------------------------
   // sticky ECRC enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecrc_gen_en_q <= 1'b0;
         ecrc_chk_en_q <= 1'b0;
      end else if (wr_en && paddr == AER_CAP_CTRL_ADDR) begin
         ecrc_gen_en_q <= pwdata[AER_ECRC_GEN_EN];
         ecrc_chk_en_q <= pwdata[AER_ECRC_CHK_EN];
      end
   end

   assign ecrc_gen_en = ecrc_gen_en_q;
   assign ecrc_chk_en = ecrc_chk_en_q;

   // ----------------------------------------------------------------
   // Secondary status and mask
   // ----------------------------------------------------------------
   // secondary status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_status_q <= AER_ZERO;
      end else begin
         sec_status_q <= aer_w1c(sec_status_q,
                                 wr_en && paddr == AER_SEC_STATUS_ADDR,
                                 pwdata, sec_ev, AER_SEC_BITS);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_mask_q <= AER_SEC_MASK_RST;
      end else if (wr_en && paddr == AER_SEC_MASK_ADDR) begin
         sec_mask_q <= pwdata & AER_SEC_BITS;
      end
   end

   // ----------------------------------------------------------------
   // First error pointer and header log
   // ----------------------------------------------------------------
   aer_log u_log (
      .pclk          (pclk),
      .presetn       (presetn),
      .unc_event     (unc_report),
      .unc_pending   (unc_pending),
      .err_header    (err_header),
      .first_err_ptr (first_err_ptr),
      .hdr_word0     (hdr_word0),
      .hdr_word1     (hdr_word1),
      .hdr_word2     (hdr_word2),
      .hdr_word3     (hdr_word3)
   );

   // ----------------------------------------------------------------
   // Error messages
   // ----------------------------------------------------------------
   // unmasked errors reported
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cor_msg      <= 1'b0;
         err_nonfatal_msg <= 1'b0;
         err_fatal_msg    <= 1'b0;
      end else begin
         err_cor_msg      <= |cor_report;
         err_nonfatal_msg <= |(unc_report & ~unc_sev_q);
         err_fatal_msg    <= |(unc_report & unc_sev_q);
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and enable
   // ----------------------------------------------------------------
   always_comb begin
      irq_ev                   = AER_ZERO;
      irq_ev[AER_IRQ_COR]      = err_cor_msg;
      irq_ev[AER_IRQ_NONFATAL] = err_nonfatal_msg;
      irq_ev[AER_IRQ_FATAL]    = err_fatal_msg;
      irq_ev[AER_IRQ_SEC]      = |sec_report;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_q <= AER_ZERO;
      end else if (!link_rst_n) begin
         irq_status_q <= AER_ZERO;
      end else begin
         irq_status_q <= aer_w1c(irq_status_q,
                                 wr_en && paddr == AER_IRQ_STATUS_ADDR,
                                 pwdata, irq_ev, AER_IRQ_BITS);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_q <= AER_ZERO;
      end else if (!link_rst_n) begin
         irq_enable_q <= AER_ZERO;
      end else if (wr_en && paddr == AER_IRQ_ENABLE_ADDR) begin
         irq_enable_q <= pwdata & AER_IRQ_BITS;
      end
   end

   assign irq = |(irq_status_q & irq_enable_q);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sev_reserved_a: assert property (
      setup && !pwrite && paddr == AER_UNC_SEV_ADDR
      |=> prdata[3:1] == 3'h0 && prdata[11:5] == 7'h00
          && prdata[31:21] == 11'h000)
      else $error("severity reserved bits not zero");

   cor_set_a: assert property (
      cor_err_det[0] |=> cor_status_q[0] && cor_status_q[31:13] == 19'h0)
      else $error("correctable event not recorded");

   cor_clear_a: assert property (
      wr_en && paddr == AER_COR_STATUS_ADDR && pwdata[12]
      && !cor_err_det[12] |=> !cor_status_q[12])
      else $error("correctable status not cleared");

   cor_mask_a: assert property (
      setup && !pwrite && paddr == AER_COR_MASK_ADDR
      |=> (prdata & ~AER_COR_BITS) == AER_ZERO)
      else $error("correctable mask reserved bits set");

   cap_read_a: assert property (
      setup && !pwrite && paddr == AER_CAP_CTRL_ADDR
      |=> prdata[AER_ECRC_GEN_CAP] && prdata[AER_ECRC_CHK_CAP]
          && prdata[31:9] == 23'h0)
      else $error("ECRC capability bits wrong");

   ecrc_write_a: assert property (
      wr_en && paddr == AER_CAP_CTRL_ADDR
      |=> ecrc_gen_en == $past(pwdata[AER_ECRC_GEN_EN])
          && ecrc_chk_en == $past(pwdata[AER_ECRC_CHK_EN]))
      else $error("ECRC enable not written");

   sec_reserved_a: assert property (
      !sec_status_q[4] && sec_status_q[31:14] == 18'h0)
      else $error("secondary reserved status bit set");

   sec_masked_a: assert property (
      sec_err_det[3] |=> sec_status_q[3])
      else $error("masked secondary event not recorded");

   fatal_msg_a: assert property (
      (unc_report & unc_sev_q) != AER_ZERO
      |=> err_fatal_msg
          ##1 (irq_status_q[AER_IRQ_FATAL] || !$past(link_rst_n)))
      else $error("fatal error not reported");

endmodule

// >>> core/aer_pkg.sv
// Register map, field layouts and helpers for the error reporting bank
package aer_pkg;

   // ----------------------------------------------------------------
   // Byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] AER_UNC_STATUS_ADDR = 12'h104;
   localparam logic [11:0] AER_UNC_MASK_ADDR   = 12'h108;
   localparam logic [11:0] AER_UNC_SEV_ADDR    = 12'h10c;
   localparam logic [11:0] AER_COR_STATUS_ADDR = 12'h110;
   localparam logic [11:0] AER_COR_MASK_ADDR   = 12'h114;
   localparam logic [11:0] AER_CAP_CTRL_ADDR   = 12'h118;
   localparam logic [11:0] AER_HDR_LOG0_ADDR   = 12'h11c;
   localparam logic [11:0] AER_HDR_LOG1_ADDR   = 12'h120;
   localparam logic [11:0] AER_HDR_LOG2_ADDR   = 12'h124;
   localparam logic [11:0] AER_HDR_LOG3_ADDR   = 12'h128;
   localparam logic [11:0] AER_SEC_STATUS_ADDR = 12'h12c;
   localparam logic [11:0] AER_SEC_MASK_ADDR   = 12'h130;
   localparam logic [11:0] AER_IRQ_STATUS_ADDR = 12'h180;
   localparam logic [11:0] AER_IRQ_ENABLE_ADDR = 12'h184;

   // ----------------------------------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] AER_UNC_BITS     = 32'h001f_f011;
   localparam logic [31:0] AER_SEV_RESET    = 32'h0006_2011;
   localparam logic [31:0] AER_COR_BITS     = 32'h0000_11c1;
   localparam logic [31:0] AER_SEC_BITS     = 32'h0000_3fef;
   localparam logic [31:0] AER_SEC_MASK_RST = 32'h0000_17a8;
   localparam logic [31:0] AER_ZERO         = 32'h0000_0000;

   // Capability and control field positions
   localparam int          AER_FEP_MSB      = 4;
   localparam int          AER_ECRC_GEN_CAP = 5;
   localparam int          AER_ECRC_GEN_EN  = 6;
   localparam int          AER_ECRC_CHK_CAP = 7;
   localparam int          AER_ECRC_CHK_EN  = 8;

   // Interrupt status layout
   localparam int          AER_IRQ_COR      = 0;
   localparam int          AER_IRQ_NONFATAL = 1;
   localparam int          AER_IRQ_FATAL    = 2;
   localparam int          AER_IRQ_SEC      = 3;
   localparam logic [31:0] AER_IRQ_BITS     = 32'h0000_000f;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Index of the lowest set bit, zero when none is set
   function automatic logic [4:0] aer_lowest(input logic [31:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   // Write-one-to-clear update in which a new event wins over the clear
   function automatic logic [31:0] aer_w1c(input logic [31:0] cur,
                                            input logic        wr,
                                            input logic [31:0] wdata,
                                            input logic [31:0] ev,
                                            input logic [31:0] bits);
      logic [31:0] clr;
      clr = wr ? wdata : AER_ZERO;
      return ((cur & ~clr) | ev) & bits;
   endfunction

endpackage

// >>> core/aer_log.sv
// First error pointer and header log capture
`timescale 1ns/10ps
module aer_log
   import aer_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [31:0]  unc_event,
   input  wire logic         unc_pending,
   input  wire logic [127:0] err_header,
   output logic      [4:0]   first_err_ptr,
   output logic      [31:0]  hdr_word0,
   output logic      [31:0]  hdr_word1,
   output logic      [31:0]  hdr_word2,
   output logic      [31:0]  hdr_word3
);

   logic capture;

   // Only the first unmasked error while none is pending is logged
   assign capture = (|unc_event) && !unc_pending;

   // ----------------------------------------------------------------
   // Capture registers, cleared only by power-on reset
   // ----------------------------------------------------------------
   // pointer to first error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_err_ptr <= 5'h00;
      end else if (capture) begin
         first_err_ptr <= aer_lowest(unc_event);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdr_word0 <= AER_ZERO;
         hdr_word1 <= AER_ZERO;
         hdr_word2 <= AER_ZERO;
         hdr_word3 <= AER_ZERO;
      end else if (capture) begin
         hdr_word0 <= err_header[127:96];
         hdr_word1 <= err_header[95:64];
         hdr_word2 <= err_header[63:32];
         hdr_word3 <= err_header[31:0];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   hdr_capture_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      capture |=> (hdr_word0 == $past(err_header[127:96]))
                  && (hdr_word3 == $past(err_header[31:0])))
      else $error("header log not captured");

   fep_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      unc_pending |=> $stable(first_err_ptr))
      else $error("first error pointer moved while error pending");

endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the error reporting register bank
`timescale 1ns/10ps
module tb_top
   import aer_pkg::*;
   ;
   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           link_rst_n = 1'b1;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [31:0]    unc_det = 32'h0;
   logic [31:0]    cor_det = 32'h0;
   logic [31:0]    sec_det = 32'h0;
   logic [127:0]   hdr = 128'h0;
   logic [31:0]    sev;
   logic           gen_en;
   logic           chk_en;
   logic           cor_msg;
   logic           nf_msg;
   logic           fat_msg;
   logic           irq;
   logic [31:0]    rdat;
   logic           rerr;
   logic [31:0]    seed = 32'hc753;
   logic [127:0]   h0;
   logic [31:0]    v;
   int             miscompares = 0;
   int             checks_done = 0;
   int             cyc = 0;

   aer_regs uut (.pclk(pclk), .presetn(presetn), .link_rst_n(link_rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .unc_err_det(unc_det), .cor_err_det(cor_det), .sec_err_det(sec_det),
      .err_header(hdr), .unc_severity(sev), .ecrc_gen_en(gen_en),
      .ecrc_chk_en(chk_en), .err_cor_msg(cor_msg),
      .err_nonfatal_msg(nf_msg), .err_fatal_msg(fat_msg), .irq(irq));

   always #10 pclk = ~pclk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] cap_exp(input logic [4:0] fep,
                                           input logic g, input logic c);
      return {23'h0, c, 1'b1, g, 1'b1, fep};
   endfunction

   function automatic logic [31:0] rst_exp(input logic [11:0] a);
      case (a)
         AER_UNC_SEV_ADDR: return AER_SEV_RESET;
         AER_CAP_CTRL_ADDR: return 32'h0000_00a0;
         AER_SEC_MASK_ADDR: return AER_SEC_MASK_RST;
         default: return 32'h0;
      endcase
   endfunction

   function automatic logic [31:0] rnd();
      seed = lfsr(seed);
      return seed;
   endfunction

   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp, $sformatf("read %h", a));
   endtask

   // Pulses one detect bus for a cycle; returns in the cycle after
   task automatic ev(input int k, input logic [31:0] d);
      @(posedge pclk);
      if (k == 0) unc_det <= d;
      if (k == 1) cor_det <= d;
      if (k == 2) sec_det <= d;
      @(posedge pclk);
      unc_det <= 32'h0;
      cor_det <= 32'h0;
      sec_det <= 32'h0;
      #1;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         v = {20'h0, 12'h104 + 12'(4 * i)};
         rd(v[11:0], rst_exp(v[11:0]));
      end
      chk(sev, AER_SEV_RESET, "severity port");
      $display("test reset done");
      h0 = {rnd(), rnd(), rnd(), rnd()};
      hdr <= h0;
      ev(0, 32'h0002_2000);
      chk({31'h0, fat_msg}, 32'h1, "fatal msg");
      @(posedge pclk) hdr <= ~h0;
      ev(0, 32'h0000_0010);
      rd(AER_UNC_STATUS_ADDR, 32'h0002_2010);
      rd(AER_CAP_CTRL_ADDR, cap_exp(5'h0d, 1'b0, 1'b0));
      for (int i = 0; i < 4; i++) begin
         rd(12'h11c + 12'(4 * i), h0[127 - 32 * i -: 32]);
      end
      ev(0, 32'h0000_1000);
      chk({30'h0, nf_msg, fat_msg}, 32'h2, "nonfatal msg");
      apb(1'b1, AER_UNC_STATUS_ADDR, 32'hffff_ffff);
      rd(AER_UNC_STATUS_ADDR, 32'h0);
      $display("test header log done");
      apb(1'b1, AER_IRQ_ENABLE_ADDR, 32'h1);
      v = rnd() | 32'h1;
      ev(1, v);
      chk({31'h0, cor_msg}, 32'h1, "cor msg");
      @(posedge pclk);
      #1 chk({31'h0, irq}, 32'h1, "irq raised");
      rd(AER_COR_STATUS_ADDR, v & AER_COR_BITS);
      // Fatal and nonfatal bits are still pending from the header test
      rd(AER_IRQ_STATUS_ADDR, 32'h7);
      apb(1'b1, AER_IRQ_ENABLE_ADDR, 32'h0);
      #1 chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, AER_IRQ_ENABLE_ADDR, 32'h1);
      #1 chk({31'h0, irq}, 32'h1, "irq unmasked");
      apb(1'b1, AER_IRQ_STATUS_ADDR, 32'h1);
      #1 chk({31'h0, irq}, 32'h0, "irq cleared");
      apb(1'b1, AER_COR_STATUS_ADDR, 32'hffff_ffff);
      rd(AER_COR_STATUS_ADDR, 32'h0);
      apb(1'b1, AER_COR_MASK_ADDR, 32'hffff_ffff);
      ev(1, 32'hffff_ffff);
      chk({31'h0, cor_msg}, 32'h0, "masked cor msg");
      rd(AER_COR_STATUS_ADDR, AER_COR_BITS);
      apb(1'b1, AER_COR_STATUS_ADDR, AER_COR_BITS);
      $display("test correctable done");
      for (int i = 0; i < 14; i++) begin
         v = 32'h1 << i;
         ev(2, v);
         rd(AER_SEC_STATUS_ADDR, v & AER_SEC_BITS);
         apb(1'b1, AER_SEC_STATUS_ADDR, v);
         rd(AER_SEC_STATUS_ADDR, 32'h0);
      end
      $display("test secondary done");
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hffff_ffff : rnd();
         apb(1'b1, AER_UNC_SEV_ADDR, v);
         #1 chk(sev, v & AER_UNC_BITS, "severity port");
         rd(AER_UNC_SEV_ADDR, v & AER_UNC_BITS);
         apb(1'b1, AER_UNC_MASK_ADDR, v);
         rd(AER_UNC_MASK_ADDR, v & AER_UNC_BITS);
         apb(1'b1, AER_COR_MASK_ADDR, v);
         rd(AER_COR_MASK_ADDR, v & AER_COR_BITS);
         apb(1'b1, AER_SEC_MASK_ADDR, v);
         rd(AER_SEC_MASK_ADDR, v & AER_SEC_BITS);
         apb(1'b1, AER_CAP_CTRL_ADDR, v);
         rd(AER_CAP_CTRL_ADDR, cap_exp(5'h0d, v[6], v[8]));
         chk({30'h0, gen_en, chk_en}, {30'h0, v[6], v[8]}, "ecrc en");
         apb(1'b1, AER_HDR_LOG1_ADDR, v);
         rd(AER_HDR_LOG1_ADDR, h0[95:64]);
      end
      $display("test read write done");
      @(posedge pclk);
      link_rst_n <= 1'b0;
      repeat (2) @(posedge pclk);
      link_rst_n <= 1'b1;
      rd(AER_UNC_SEV_ADDR, v & AER_UNC_BITS);
      rd(AER_SEC_MASK_ADDR, v & AER_SEC_BITS);
      rd(AER_CAP_CTRL_ADDR, cap_exp(5'h0d, v[6], v[8]));
      rd(AER_HDR_LOG3_ADDR, h0[31:0]);
      rd(AER_IRQ_ENABLE_ADDR, 32'h0);
      rd(AER_IRQ_STATUS_ADDR, 32'h0);
      $display("test link reset done");
      apb(1'b1, 12'h1fc, 32'hffff_ffff);
      chk({31'h0, rerr}, 32'h1, "unmapped write");
      rd(12'h1fc, 32'h0);
      chk({31'h0, rerr}, 32'h1, "unmapped read");
      rd(AER_COR_MASK_ADDR, v & AER_COR_BITS);
      chk({31'h0, rerr}, 32'h0, "mapped read");
      chk({31'h0, pready}, 32'h1, "ready level");
      $display("test unmapped done");
      finish_test();
   end
endmodule
